/* File: hdl/sps_i2c_slave.sv */
// Strap decoder and two-wire register slave with write buffer
`timescale 1ns/10ps
`default_nettype none
module sps_i2c_slave #(
    parameter int AW = sps_pkg::ADDR_WIDTH,
    parameter int DW = sps_pkg::DATA_WIDTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] portStrapUpper,
    input wire logic [1:0] portStrapLower,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    output logic spiEnable,
    output logic i2cEnable,
    output logic [6:0] slaveAddr,
    output logic [AW-1:0] regAddr,
    output logic wrValid,
    output logic [AW-1:0] wrAddr,
    output logic [DW-1:0] wrData,
    input wire logic wrReady,
    input wire logic [DW-1:0] rdData
);
    // ************************************************
    // Helpers
    // ************************************************
    // Three-level code to 0..2, unknown code read as open
    function automatic logic [3:0] trit(input logic [1:0] c);
        begin
            if (c == sps_pkg::STRAP_LOW) begin
                trit = 4'h0;
            end else if (c == sps_pkg::STRAP_HIGH) begin
                trit = 4'h2;
            end else begin
                trit = 4'h1;
            end
        end
    endfunction : trit

    function automatic logic [3:0] strapIndex(input logic [1:0] u,
                                              input logic [1:0] l);
        begin
            strapIndex = 4'((trit(u) * 4'h3) + trit(l));
        end
    endfunction : strapIndex

    // ************************************************
    // Input synchronisers
    // ************************************************
    logic sclS1, sclS2, sclQ, sdaS1, sdaS2, sdaQ;
    logic [1:0] upS1, upS2, loS1, loS2;
    // Two flops per pin, third stage only for edges
    always_ff @(posedge clk_sys) begin
        sclS1 <= scl;
        sclS2 <= sclS1;
        sclQ <= sclS2;
        sdaS1 <= sdaIn;
        sdaS2 <= sdaS1;
        sdaQ <= sdaS2;
        upS1 <= portStrapUpper;
        upS2 <= upS1;
        loS1 <= portStrapLower;
        loS2 <= loS1;
    end

    // Edge and condition detect, fine at 100 or 400 kHz [RULE_04]
    logic sclRise, sclFall, startDet, stopDet;
    assign sclRise = sclS2 && !sclQ;
    assign sclFall = !sclS2 && sclQ;
    assign startDet = sclS2 && sclQ && sdaQ && !sdaS2; // [RULE_09]
    assign stopDet = sclS2 && sclQ && !sdaQ && sdaS2; // [RULE_10]

    // ************************************************
    // Strap capture after reset release
    // ************************************************
    logic [1:0] strapCnt, next_strapCnt;
    logic strapDone, next_strapDone;
    logic next_spiEnable, next_i2cEnable;
    logic [6:0] next_slaveAddr;
    logic [3:0] idx;
    // Latch straps once the synchronisers have settled
    always_comb begin
        idx = strapIndex(upS2, loS2);
        next_strapCnt = strapCnt;
        next_strapDone = strapDone;
        next_spiEnable = spiEnable;
        next_i2cEnable = i2cEnable;
        next_slaveAddr = slaveAddr;
        if (!strapDone) begin
            next_strapCnt = 2'(strapCnt + 2'h1);
            if (strapCnt == sps_pkg::STRAP_SETTLE) begin
                next_strapDone = 1'b1;
                next_spiEnable = (idx == sps_pkg::SPI_INDEX); // [RULE_01]
                next_i2cEnable = (idx != sps_pkg::SPI_INDEX); // [RULE_19]
                next_slaveAddr = {sps_pkg::ADDR_UPPER, idx[2:0]}; // [RULE_02] [RULE_03]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strapCnt <= 2'h0;
            strapDone <= 1'b0;
            spiEnable <= 1'b0;
            i2cEnable <= 1'b0;
            slaveAddr <= 7'h00;
        end else begin
            strapCnt <= next_strapCnt;
            strapDone <= next_strapDone;
            spiEnable <= next_spiEnable;
            i2cEnable <= next_i2cEnable;
            slaveAddr <= next_slaveAddr;
        end
    end

    // ************************************************
    // Two-entry write buffer
    // ************************************************
    logic push, full;
    logic v1, next_v1, next_wrValid;
    logic [AW-1:0] a1, next_a1, next_wrAddr, pushAddr;
    logic [DW-1:0] d1, next_d1, next_wrData, pushData;
    assign full = v1;
    // Slot 0 is the head; a push lands in the first free slot
    always_comb begin
        next_wrValid = wrValid;
        next_wrAddr = wrAddr;
        next_wrData = wrData;
        next_v1 = v1;
        next_a1 = a1;
        next_d1 = d1;
        if (wrValid && wrReady) begin
            next_wrValid = v1;
            next_wrAddr = a1;
            next_wrData = d1;
            next_v1 = 1'b0;
        end
        if (push) begin
            if (!next_wrValid) begin
                next_wrValid = 1'b1;
                next_wrAddr = pushAddr;
                next_wrData = pushData;
            end else begin
                next_v1 = 1'b1;
                next_a1 = pushAddr;
                next_d1 = pushData;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrValid <= 1'b0;
            wrAddr <= '0;
            wrData <= '0;
            v1 <= 1'b0;
            a1 <= '0;
            d1 <= '0;
        end else begin
            wrValid <= next_wrValid;
            wrAddr <= next_wrAddr;
            wrData <= next_wrData;
            v1 <= next_v1;
            a1 <= next_a1;
            d1 <= next_d1;
        end
    end

    // ************************************************
    // Bus protocol engine
    // ************************************************
    sps_pkg::sps_state_e state, next_state;
    logic [3:0] bitCnt, next_bitCnt;
    logic [1:0] byteIdx, next_byteIdx;
    logic [7:0] sh, next_sh;
    logic rw, next_rw, ackOk, next_ackOk;
    logic next_sdaOeN;
    logic [AW-1:0] next_regAddr;
    assign pushAddr = regAddr;
    assign pushData = sh;
    // Clock line is input only; slave never drives it [RULE_05]
    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_byteIdx = byteIdx;
        next_sh = sh;
        next_rw = rw;
        next_ackOk = ackOk;
        next_sdaOeN = sdaOeN;
        next_regAddr = regAddr;
        push = 1'b0;
        if (!i2cEnable) begin
            next_state = sps_pkg::ST_IDLE; // [RULE_19]
            next_sdaOeN = 1'b1;
        end else if (stopDet) begin
            next_state = sps_pkg::ST_IDLE; // [RULE_10] [RULE_17]
            next_sdaOeN = 1'b1;
        end else if (startDet) begin
            // Fresh or repeated start drops any partial byte [RULE_17]
            next_state = sps_pkg::ST_RX;
            next_bitCnt = 4'h0;
            next_byteIdx = sps_pkg::BYTE_SLAVE;
            next_sdaOeN = 1'b1;
        end else begin
            case (state)
                sps_pkg::ST_IDLE: begin
                    next_sdaOeN = 1'b1;
                end
                sps_pkg::ST_RX: begin
                    // One bit per clock pulse, MSB first [RULE_07] [RULE_11]
                    if (sclRise && bitCnt < sps_pkg::BITS_PER_BYTE) begin
                        next_sh = {sh[6:0], sdaS2};
                        next_bitCnt = 4'(bitCnt + 4'h1);
                    end else if (sclFall
                                 && bitCnt == sps_pkg::BITS_PER_BYTE) begin
                        next_state = sps_pkg::ST_RXACK;
                        next_sdaOeN = 1'b0; // [RULE_12]
                        case (byteIdx)
                            sps_pkg::BYTE_SLAVE: begin
                                // Only a matching address answers [RULE_14]
                                if (sh[7:1] == slaveAddr) begin
                                    next_rw = sh[0];
                                end else begin
                                    next_state = sps_pkg::ST_IDLE;
                                    next_sdaOeN = 1'b1;
                                end
                            end
                            sps_pkg::BYTE_ADDR_HI: begin
                                next_regAddr = {sh, regAddr[7:0]}; // [RULE_06]
                            end
                            sps_pkg::BYTE_ADDR_LO: begin
                                next_regAddr = {regAddr[AW-1:8], sh}; // [RULE_15]
                            end
                            default: begin
                                if (full) begin
                                    next_sdaOeN = 1'b1; // [RULE_13]
                                end else begin
                                    push = 1'b1;
                                    next_regAddr = AW'(regAddr + 1'b1); // [RULE_18]
                                end
                            end
                        endcase
                    end
                end
                sps_pkg::ST_RXACK: begin
                    if (sclFall) begin
                        next_bitCnt = 4'h0;
                        if (byteIdx != sps_pkg::BYTE_DATA) begin
                            next_byteIdx = 2'(byteIdx + 2'h1);
                        end
                        if (byteIdx == sps_pkg::BYTE_SLAVE && rw) begin
                            // Read from the current address [RULE_16]
                            next_state = sps_pkg::ST_TX;
                            next_sh = rdData;
                            next_sdaOeN = rdData[7];
                            next_regAddr = AW'(regAddr + 1'b1); // [RULE_18]
                        end else if (sdaOeN) begin
                            next_state = sps_pkg::ST_IDLE;
                        end else begin
                            next_state = sps_pkg::ST_RX;
                            next_sdaOeN = 1'b1;
                        end
                    end
                end
                sps_pkg::ST_TX: begin
                    // Drive changes only after a falling clock [RULE_08]
                    if (sclFall) begin
                        next_bitCnt = 4'(bitCnt + 4'h1);
                        next_sh = {sh[6:0], 1'b1};
                        next_sdaOeN = sh[6];
                        if (bitCnt == 4'(sps_pkg::BITS_PER_BYTE - 4'h1)) begin
                            next_state = sps_pkg::ST_TXACK;
                            next_sdaOeN = 1'b1;
                        end
                    end
                end
                sps_pkg::ST_TXACK: begin
                    if (sclRise) begin
                        next_ackOk = !sdaS2; // [RULE_12] [RULE_13]
                    end else if (sclFall) begin
                        next_bitCnt = 4'h0;
                        if (ackOk) begin
                            next_state = sps_pkg::ST_TX;
                            next_sh = rdData;
                            next_sdaOeN = rdData[7];
                            next_regAddr = AW'(regAddr + 1'b1); // [RULE_18]
                        end else begin
                            next_state = sps_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = sps_pkg::ST_IDLE;
                    next_sdaOeN = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= sps_pkg::ST_IDLE;
            bitCnt <= 4'h0;
            byteIdx <= 2'h0;
            sh <= 8'h00;
            rw <= 1'b0;
            ackOk <= 1'b0;
            sdaOeN <= 1'b1;
            sdaOut <= 1'b0;
            regAddr <= '0;
        end else begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            byteIdx <= next_byteIdx;
            sh <= next_sh;
            rw <= next_rw;
            ackOk <= next_ackOk;
            sdaOeN <= next_sdaOeN;
            sdaOut <= 1'b0;
            regAddr <= next_regAddr;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_portSel;
        @(posedge clk_sys) disable iff (rst)
        strapDone |-> (spiEnable != i2cEnable);
    endproperty
    a_portSel: assert property (p_portSel) // [RULE_01]
        else $error("port selects not exclusive");

    property p_addrUpper;
        @(posedge clk_sys) disable iff (rst)
        $rose(strapDone) |-> slaveAddr[6:3] == sps_pkg::ADDR_UPPER;
    endproperty
    a_addrUpper: assert property (p_addrUpper) // [RULE_02]
        else $error("slave address upper bits wrong");

    property p_addrMap;
        @(posedge clk_sys) disable iff (rst)
        $rose(strapDone) && i2cEnable
            |-> slaveAddr[2:0] == $past(idx[2:0]);
    endproperty
    a_addrMap: assert property (p_addrMap) // [RULE_03]
        else $error("slave address low bits wrong");

    property p_driveOnLow;
        @(posedge clk_sys) disable iff (rst)
        $fell(sdaOeN) |-> !$past(sclS2) || $past(startDet || stopDet);
    endproperty
    a_driveOnLow: assert property (p_driveOnLow) // [RULE_08]
        else $error("data driven while clock high");

    property p_stopIdle;
        @(posedge clk_sys) disable iff (rst)
        stopDet |=> state == sps_pkg::ST_IDLE && sdaOeN;
    endproperty
    a_stopIdle: assert property (p_stopIdle) // [RULE_10]
        else $error("stop did not return to idle");

    property p_startRx;
        @(posedge clk_sys) disable iff (rst)
        startDet && i2cEnable
            |=> state == sps_pkg::ST_RX && bitCnt == 4'h0;
    endproperty
    a_startRx: assert property (p_startRx) // [RULE_09] [RULE_17]
        else $error("start did not restart reception");

    property p_addrStep;
        @(posedge clk_sys) disable iff (rst)
        push |=> regAddr == AW'($past(regAddr) + 1'b1) && wrValid;
    endproperty
    a_addrStep: assert property (p_addrStep) // [RULE_18]
        else $error("address did not advance on write");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        wrValid && !wrReady |=> wrValid && $stable(wrAddr);
    endproperty
    a_hold: assert property (p_hold) // [RULE_15]
        else $error("buffered word lost under stall");

    property p_spiQuiet;
        @(posedge clk_sys) disable iff (rst)
        spiEnable |=> state == sps_pkg::ST_IDLE && sdaOeN;
    endproperty
    a_spiQuiet: assert property (p_spiQuiet) // [RULE_19]
        else $error("two-wire slave active in SPI mode");
endmodule : sps_i2c_slave
`default_nettype wire

/* File: hdl/sps_pkg.sv */
// Constants of the strap decoder and two-wire slave
// Summary of operation
// RULE_01 - Sample two three-level straps; both high selects SPI, otherwise two-wire slave
// RULE_02 - Slave address upper four bits are fixed at 1011
// RULE_03 - Strap pairs in order low/low to high/open give addresses 1011000 to 1011111
// RULE_04 - Works at 100 kHz and 400 kHz bus clock rates
// RULE_05 - Slave only; the serial clock line is never driven
// RULE_06 - Register addresses are sixteen bits, sent as two bytes
// RULE_07 - Master gives one clock pulse per data bit
// RULE_08 - Data line changes only while the clock is low
// RULE_09 - Data falling while clock high is a start; it is detected
// RULE_10 - Data rising while clock high is a stop; slave returns to idle
// RULE_11 - Bytes are eight bits, MSB first, each followed by an acknowledge slot
// RULE_12 - Receiver acknowledges by pulling data low on the ninth pulse
// RULE_13 - Receiver refuses a byte by leaving data high on the ninth pulse
// RULE_14 - Address byte is seven address bits then direction; only a match acknowledges
// RULE_15 - Write: two address bytes high first, then unlimited data bytes
// RULE_16 - Read returns data from the current address; repeated start keeps it
// RULE_17 - Start or stop at any point abandons the partial byte
// RULE_18 - Register address advances after each data byte read or written
// RULE_19 - Only the selected port is active; the other stays idle
package sps_pkg;
    // ************************************************
    // Strap codes and address
    // ************************************************
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_OPEN = 2'h1;
    localparam logic [1:0] STRAP_HIGH = 2'h2;
    localparam logic [3:0] SPI_INDEX = 4'h8;
    localparam logic [3:0] ADDR_UPPER = 4'hb;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Byte positions within a write
    localparam logic [1:0] BYTE_SLAVE = 2'h0;
    localparam logic [1:0] BYTE_ADDR_HI = 2'h1;
    localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
    localparam logic [1:0] BYTE_DATA = 2'h3;
    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RXACK,
        ST_TX,
        ST_TXACK
    } sps_state_e;
endpackage : sps_pkg

/* File: bench/sps_i2c_master.sv */
// Two-wire bus master model driving the clock and data lines
`timescale 1ns/10ps
`default_nettype none
module sps_i2c_master (
    input wire logic clk_sys,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrv
);
    // ************************************************
    // Bus timing and line state
    // ************************************************
    int hp = 4; // Half period in system clocks
    // Clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // One clock pulse per bit, data moved only while clock low
    task automatic clkBit(input logic b, output logic s);
        @(posedge clk_sys) sdaDrv <= b;
        repeat (hp - 1) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (hp - 1) @(posedge clk_sys);
        @(negedge clk_sys) s = sdaLine;
        @(posedge clk_sys) scl <= 1'b0;
    endtask : clkBit
    // Data falls while clock high
    task automatic start();
        @(posedge clk_sys) sdaDrv <= 1'b1;
        repeat (hp) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (hp) @(posedge clk_sys);
        sdaDrv <= 1'b0;
        repeat (hp) @(posedge clk_sys);
        scl <= 1'b0;
    endtask : start
    // Data rises while clock high, clock then stands high
    task automatic stop();
        @(posedge clk_sys) sdaDrv <= 1'b0;
        repeat (hp) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (hp) @(posedge clk_sys);
        sdaDrv <= 1'b1;
        repeat (hp) @(posedge clk_sys);
    endtask : stop
    // Eight bits MSB first, then ack slot with line released
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(d[i], s);
        end
        clkBit(1'b1, s);
        ack = ~s;
    endtask : wbyte
    // Read eight bits, then answer with ack or nack
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(1'b1, s);
            d[i] = s;
        end
        clkBit(nack, s);
    endtask : rbyte
endmodule : sps_i2c_master
`default_nettype wire

/* File: bench/sps_i2c_slave_tb_top.sv */
// Self-checking bench of the strap decoder and two-wire slave
`timescale 1ns/10ps
`default_nettype none
module sps_i2c_slave_tb_top;
    // ************************************************
    // Signals and models
    // ************************************************
    localparam logic [6:0] DEV = 7'h5c; // Address for open/open straps
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] portStrapUpper = 2'h1;
    logic [1:0] portStrapLower = 2'h1;
    logic scl;
    logic sdaDrv;
    logic sdaLine;
    logic sdaOut;
    logic sdaOeN;
    logic spiEnable;
    logic i2cEnable;
    logic [6:0] slaveAddr;
    logic [15:0] regAddr;
    logic [15:0] wrAddr;
    logic wrValid;
    logic wrReady = 1'b1;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic [23:0] wq[$];
    int n_fail = 0;
    int checked = 0;
    always #12.5 clk_sys = ~clk_sys;
    // Open-drain line with pull-up; registers read back as address xor 5a
    assign sdaLine = sdaDrv & (sdaOeN | sdaOut);
    assign rdData = regAddr[7:0] ^ 8'h5a;
    // Write consumer collects popped words
    always @(posedge clk_sys) begin
        if (wrValid === 1'b1 && wrReady === 1'b1) begin
            wq.push_back({wrAddr, wrData});
        end
    end
    sps_i2c_slave dut (.clk_sys(clk_sys), .rst(rst),
        .portStrapUpper(portStrapUpper), .portStrapLower(portStrapLower),
        .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .spiEnable(spiEnable), .i2cEnable(i2cEnable), .slaveAddr(slaveAddr),
        .regAddr(regAddr), .wrValid(wrValid), .wrAddr(wrAddr),
        .wrData(wrData), .wrReady(wrReady), .rdData(rdData));
    sps_i2c_master mst (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl),
        .sdaDrv(sdaDrv));
    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic doReset();
        @(posedge clk_sys) rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : doReset
    task automatic sendB(input logic [7:0] d, input logic expAck);
        logic ack;
        mst.wbyte(d, ack);
        chk({31'h0, ack}, {31'h0, expAck});
    endtask : sendB
    task automatic setAddr(input logic [15:0] a);
        mst.start();
        sendB({DEV, 1'b0}, 1'b1);
        sendB(a[15:8], 1'b1);
        sendB(a[7:0], 1'b1);
    endtask : setAddr
    task automatic popWord(input logic [15:0] a, input logic [7:0] d);
        for (int k = 0; k < 100 && wq.size() == 0; k++) begin
            @(posedge clk_sys);
        end
        if (wq.size() == 0) begin
            n_fail++;
            final_report();
        end else begin
            chk({8'h00, wq.pop_front()}, {8'h00, a, d});
        end
    endtask : popWord
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_straps();
        logic [3:0] idx;
        for (int i = 0; i < 9; i++) begin
            idx = 4'(i);
            portStrapUpper <= 2'(i / 3);
            portStrapLower <= 2'(i % 3);
            doReset();
            chk({31'h0, spiEnable}, {31'h0, idx == 4'h8});
            chk({31'h0, i2cEnable}, {31'h0, idx != 4'h8});
            if (i < 8) begin
                chk({25'h0, slaveAddr}, {25'h0, 4'hb, idx[2:0]});
            end
        end
        mst.start();
        sendB({7'h58, 1'b0}, 1'b0);
        mst.stop();
        portStrapUpper <= 2'h1;
        portStrapLower <= 2'h1;
        doReset();
    endtask : t_straps
    task automatic t_write();
        setAddr(16'h1234);
        sendB(8'ha5, 1'b1);
        sendB(8'h5a, 1'b1);
        sendB(8'h3c, 1'b1);
        mst.stop();
        chk({31'h0, sdaOeN}, 32'h1);
        popWord(16'h1234, 8'ha5);
        popWord(16'h1235, 8'h5a);
        popWord(16'h1236, 8'h3c);
        chk({16'h0, regAddr}, 32'h1237);
    endtask : t_write
    task automatic t_wrong();
        mst.start();
        sendB({DEV ^ 7'h01, 1'b0}, 1'b0);
        sendB(8'hff, 1'b0);
        mst.stop();
        chk(32'(wq.size()), 32'h0);
    endtask : t_wrong
    task automatic t_abort();
        logic s;
        setAddr(16'h0040);
        for (int i = 0; i < 4; i++) begin
            mst.clkBit(1'b0, s);
        end
        setAddr(16'h0010);
        sendB(8'h77, 1'b1);
        mst.stop();
        popWord(16'h0010, 8'h77);
    endtask : t_abort
    task automatic t_read();
        logic [7:0] d;
        setAddr(16'h0020);
        mst.start();
        sendB({DEV, 1'b1}, 1'b1);
        mst.rbyte(1'b0, d);
        chk({24'h0, d}, 32'h20 ^ 32'h5a);
        mst.rbyte(1'b0, d);
        chk({24'h0, d}, 32'h21 ^ 32'h5a);
        mst.rbyte(1'b1, d);
        chk({24'h0, d}, 32'h22 ^ 32'h5a);
        mst.stop();
        chk({31'h0, sdaOeN}, 32'h1);
    endtask : t_read
    task automatic t_full();
        wrReady <= 1'b0;
        setAddr(16'h0100);
        sendB(8'h11, 1'b1);
        sendB(8'h22, 1'b1);
        sendB(8'h33, 1'b0);
        sendB(8'h44, 1'b0);
        mst.stop();
        @(posedge clk_sys) wrReady <= 1'b1;
        popWord(16'h0100, 8'h11);
        popWord(16'h0101, 8'h22);
        repeat (4) @(posedge clk_sys);
        chk(32'(wq.size()), 32'h0);
        chk({31'h0, wrValid}, 32'h0);
        chk({16'h0, regAddr}, 32'h0102);
    endtask : t_full
    task automatic t_rates();
        for (int k = 0; k < 2; k++) begin
            mst.hp = (k == 0) ? 200 : 50;
            setAddr(16'h0300 + 16'(k));
            sendB(8'hc0 + 8'(k), 1'b1);
            mst.stop();
            popWord(16'h0300 + 16'(k), 8'hc0 + 8'(k));
        end
        mst.hp = 4;
    endtask : t_rates
    // ************************************************
    // Main sequence and hang guard
    // ************************************************
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        t_straps();
        t_write();
        t_wrong();
        t_abort();
        t_read();
        t_full();
        t_rates();
        final_report();
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end
endmodule : sps_i2c_slave_tb_top
`default_nettype wire
